// File: csub_pkg.sv
// package of constants and types for the control switch and user button block
package csub_pkg;
    localparam int unsigned CSUB_NUM_SW = 5;
    localparam int unsigned CSUB_NUM_BTN = 12;
    localparam int unsigned CSUB_NAME_CHARS = 32;
    localparam int unsigned CSUB_TS_W = 32;
    localparam int unsigned CSUB_CLK_HZ = 50_000_000;
    // debounce settle time in microseconds
    localparam int unsigned CSUB_DEB_US = 10;
    localparam int unsigned CSUB_DEB_CYC = (CSUB_DEB_US * (CSUB_CLK_HZ / 1_000_000) > 0) ?
        CSUB_DEB_US * (CSUB_CLK_HZ / 1_000_000) : 1;
    localparam int unsigned CSUB_DEB_W = $clog2(CSUB_DEB_CYC + 1);
    // access levels, lowest first
    typedef enum logic [1:0] {
        CSUB_LVL_USER,
        CSUB_LVL_OPERATOR,
        CSUB_LVL_CONFIG,
        CSUB_LVL_SUPER
    } csub_level_t;
    localparam csub_level_t CSUB_LVL_RESET = CSUB_LVL_CONFIG;
    // which switch events reach the event buffer
    localparam logic [1:0] CSUB_EVSEL_ON = 2'h1;
    localparam logic [1:0] CSUB_EVSEL_OFF = 2'h2;
    localparam logic [1:0] CSUB_EVSEL_BOTH = 2'h3;
    localparam logic [1:0] CSUB_EVSEL_RESET = 2'h3;
    // button mode: 0 momentary, 1 toggle
    localparam logic CSUB_MODE_MOMENTARY = 1'b0;
    localparam logic CSUB_MODE_TOGGLE = 1'b1;
    localparam logic [2:0] CSUB_SYNC_STAGES = 3'h2;
endpackage : csub_pkg

// File: csub_top.sv
// control switches and front-panel user buttons
`timescale 1ns/1ps
`default_nettype none

// Function
// - switch holds state until opposite command
// - only mimic or remote terminal commands
// - five independent switches, outputs exported
// - separate ON and OFF events per change
// - each recorded event carries time stamp
// - event selection: ON, OFF or both
// - mimic command needs configured access level
// - settable 32-character name per switch
// - twelve buttons, each own status
// - per-button mode, momentary default
// - momentary status follows physical press
// - toggle inverts status once per press
// - three-colour LED from selectable sources
// - buttons ignore remote commands entirely
// - complementary On and Off outputs
module csub_top
    import csub_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [CSUB_TS_W-1:0] time_now,
    input wire logic [CSUB_NUM_SW-1:0] mimic_on_req,
    input wire logic [CSUB_NUM_SW-1:0] mimic_off_req,
    input wire logic [1:0] mimic_level,
    input wire logic [1:0] access_level_cfg,
    input wire logic [CSUB_NUM_SW-1:0] rtu_on_req,
    input wire logic [CSUB_NUM_SW-1:0] rtu_off_req,
    input wire logic [1:0] event_sel_cfg,
    input wire logic name_wr,
    input wire logic [2:0] name_sw,
    input wire logic [4:0] name_idx,
    input wire logic [7:0] name_char,
    input wire logic [2:0] name_rd_sw,
    input wire logic [4:0] name_rd_idx,
    output logic [7:0] name_rd_char,
    output logic [CSUB_NUM_SW-1:0] switch_out,
    output logic event_valid,
    output logic [2:0] event_switch,
    output logic event_is_on,
    output logic [CSUB_TS_W-1:0] event_time,
    input wire logic [CSUB_NUM_BTN-1:0] button_raw,
    input wire logic [CSUB_NUM_BTN-1:0] button_mode_cfg,
    input wire logic [CSUB_NUM_BTN-1:0] led_red_src,
    input wire logic [CSUB_NUM_BTN-1:0] led_orange_src,
    input wire logic [CSUB_NUM_BTN-1:0] led_green_src,
    output logic [CSUB_NUM_BTN-1:0] button_on,
    output logic [CSUB_NUM_BTN-1:0] button_off,
    output logic [CSUB_NUM_BTN-1:0] led_red,
    output logic [CSUB_NUM_BTN-1:0] led_orange,
    output logic [CSUB_NUM_BTN-1:0] led_green
);

    // ---------------------------------------------
    // state
    // ---------------------------------------------
    typedef struct packed {
        logic [CSUB_NUM_SW-1:0] sw;
        logic [CSUB_NUM_SW-1:0] pend_on;
        logic [CSUB_NUM_SW-1:0] pend_off;
        logic ev_valid;
        logic [2:0] ev_sw;
        logic ev_on;
        logic [CSUB_TS_W-1:0] ev_time;
        logic [CSUB_NUM_BTN-1:0] sync1;
        logic [CSUB_NUM_BTN-1:0] sync2;
        logic [CSUB_NUM_BTN-1:0] deb;
        logic [CSUB_NUM_BTN-1:0][CSUB_DEB_W-1:0] cnt;
        logic [CSUB_NUM_BTN-1:0] tog;
    } csub_state_t;

    csub_state_t s_q;
    csub_state_t s_d;
    logic [CSUB_NUM_SW-1:0][CSUB_NAME_CHARS-1:0][7:0] name_q;

    // access check shared by all switches
    function automatic logic csub_level_ok(input logic [1:0] have, input logic [1:0] need);
        csub_level_ok = (have >= need);
    endfunction

    // event kind filter
    function automatic logic csub_ev_kept(input logic on, input logic [1:0] sel);
        csub_ev_kept = on ? sel[0] : sel[1];
    endfunction

    logic [CSUB_NUM_SW-1:0] cmd_on;
    logic [CSUB_NUM_SW-1:0] cmd_off;
    logic mimic_ok;
    logic [CSUB_NUM_BTN-1:0] btn_status;

    // ---------------------------------------------
    // next-state logic
    // ---------------------------------------------
    always_comb begin
        logic found;
        logic [CSUB_NUM_SW-1:0] chg;
        found = 1'b0;
        chg = '0;
        s_d = s_q;
        mimic_ok = csub_level_ok(mimic_level, access_level_cfg);
        // only mimic and remote ports reach the switches; on+off together is ignored
        cmd_on = ((mimic_on_req & {CSUB_NUM_SW{mimic_ok}}) | rtu_on_req);
        cmd_off = ((mimic_off_req & {CSUB_NUM_SW{mimic_ok}}) | rtu_off_req);
        for (int i = 0; i < CSUB_NUM_SW; i++) begin
            // each switch latches independently
            if (cmd_on[i] && !cmd_off[i] && !s_q.sw[i]) begin
                s_d.sw[i] = 1'b1;
                chg[i] = 1'b1;
                s_d.pend_on[i] = csub_ev_kept(1'b1, event_sel_cfg);
                s_d.pend_off[i] = 1'b0;
            end else if (cmd_off[i] && !cmd_on[i] && s_q.sw[i]) begin
                s_d.sw[i] = 1'b0;
                chg[i] = 1'b1;
                s_d.pend_off[i] = csub_ev_kept(1'b0, event_sel_cfg);
                s_d.pend_on[i] = 1'b0;
            end
        end
        // issue one pending event per cycle, lowest switch first
        s_d.ev_valid = 1'b0;
        for (int i = 0; i < CSUB_NUM_SW; i++) begin
            if (!found && (s_q.pend_on[i] || s_q.pend_off[i])) begin
                found = 1'b1;
                s_d.ev_valid = 1'b1;
                s_d.ev_sw = 3'(i);
                s_d.ev_on = s_q.pend_on[i];
                s_d.ev_time = time_now;
                // a change in this same cycle must not lose its own event
                if (!chg[i]) begin
                    s_d.pend_on[i] = 1'b0;
                    s_d.pend_off[i] = 1'b0;
                end
            end
        end
        // buttons: two-flop sync then settle counter; no remote path exists
        s_d.sync1 = button_raw;
        s_d.sync2 = s_q.sync1;
        for (int b = 0; b < CSUB_NUM_BTN; b++) begin
            if (s_q.sync2[b] == s_q.deb[b]) begin
                s_d.cnt[b] = '0;
            end else if (s_q.cnt[b] == CSUB_DEB_W'(CSUB_DEB_CYC - 1)) begin
                s_d.cnt[b] = '0;
                s_d.deb[b] = s_q.sync2[b];
                // one debounced rising edge per press
                if (s_q.sync2[b] && button_mode_cfg[b] == CSUB_MODE_TOGGLE) begin
                    s_d.tog[b] = ~s_q.tog[b];
                end
            end else begin
                s_d.cnt[b] = s_q.cnt[b] + 1'b1;
            end
        end
    end

    // ---------------------------------------------
    // registers; reset gives all Off, no events
    // ---------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // name storage kept without reset: text, not control state
    always_ff @(posedge core_clk) begin
        if (name_wr && name_sw < 3'(CSUB_NUM_SW)) begin
            name_q[name_sw][name_idx] <= name_char;
        end
        name_rd_char <= (name_rd_sw < 3'(CSUB_NUM_SW)) ? name_q[name_rd_sw][name_rd_idx] : 8'h00;
    end

    // ---------------------------------------------
    // outputs
    // ---------------------------------------------
    always_comb begin
        for (int b = 0; b < CSUB_NUM_BTN; b++) begin
            btn_status[b] = (button_mode_cfg[b] == CSUB_MODE_TOGGLE) ?
                s_q.tog[b] : s_q.deb[b];
        end
    end

    assign switch_out = s_q.sw;
    assign event_valid = s_q.ev_valid;
    assign event_switch = s_q.ev_sw;
    assign event_is_on = s_q.ev_on;
    assign event_time = s_q.ev_time;
    assign button_on = btn_status;
    assign button_off = ~btn_status;
    // led sources are picked outside; here they pass straight through per colour
    assign led_red = led_red_src;
    assign led_orange = led_orange_src;
    assign led_green = led_green_src;

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    AST_SW_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!$past(cmd_on[0]) && !$past(cmd_off[0])) |-> $stable(switch_out[0]))
        else $error("switch changed without command");
    AST_LEVEL: assert property (@(posedge core_clk) disable iff (!rst_b)
        (mimic_on_req[2] && !rtu_on_req[2] && mimic_level < access_level_cfg && !switch_out[2])
        |=> !switch_out[2])
        else $error("mimic command accepted below access level");
    AST_ON_EVENT: assert property (@(posedge core_clk) disable iff (!rst_b)
        ($rose(switch_out[0]) && $past(event_sel_cfg[0]))
        |-> ##[1:5] (event_valid && event_switch == 3'h0 && event_is_on))
        else $error("missing ON event");
    AST_SEL: assert property (@(posedge core_clk) disable iff (!rst_b)
        event_valid |-> csub_ev_kept(event_is_on, $past(event_sel_cfg, 2)))
        else $error("filtered event issued");
    AST_STAMP: assert property (@(posedge core_clk) disable iff (!rst_b)
        event_valid |-> event_time == $past(time_now))
        else $error("event time stamp wrong");
    AST_COMPL: assert property (@(posedge core_clk) disable iff (!rst_b)
        button_on == ~button_off)
        else $error("button outputs not complementary");
    AST_MOMENT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (button_mode_cfg[0] == CSUB_MODE_MOMENTARY) |-> button_on[0] == s_q.deb[0])
        else $error("momentary status differs from press");
    AST_TOGGLE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (button_mode_cfg[1] && $stable(button_mode_cfg[1]) && !$rose(s_q.deb[1]))
        |-> $stable(button_on[1]))
        else $error("toggle status changed without press");
    AST_RESET: assert property (@(posedge core_clk)
        $rose(rst_b) |-> (switch_out == '0 && !event_valid))
        else $error("state not cleared by reset");
    COV_SW_ON: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(switch_out[0]));
    COV_EVENT: cover property (@(posedge core_clk) disable iff (!rst_b) event_valid);
    COV_TOG: cover property (@(posedge core_clk) disable iff (!rst_b)
        button_mode_cfg[1] && $rose(button_on[1]));

endmodule // csub_top

`default_nettype wire

// File: csub_panel.sv
// operator panel model: user buttons with contact chatter
`timescale 1ns/1ps
`default_nettype none
module csub_panel (
    input wire logic core_clk,
    output logic [11:0] button_raw
);
    initial button_raw = 12'h000;
    // chatter far shorter than the settle time, then a clean level
    task automatic bounce(input int i, input logic lvl);
        repeat (3) begin
            repeat (7) @(posedge core_clk);
            button_raw[i] <= lvl;
            repeat (5) @(posedge core_clk);
            button_raw[i] <= !lvl;
        end
        @(posedge core_clk);
        button_raw[i] <= lvl;
    endtask
endmodule // csub_panel
`default_nettype wire

// File: control_switch_and_user_buttons_bench.sv
// self-checking bench for the control switch and user button block
`timescale 1ns/1ps
`default_nettype none
module control_switch_and_user_buttons_bench import csub_pkg::*;;
    logic core_clk = 1'b0, rst_b = 1'b0, name_wr = 1'b0, event_valid, event_is_on;
    logic [31:0] time_now = 32'h0000_0000, event_time;
    logic [4:0] mimic_on_req = 5'h00, mimic_off_req = 5'h00, rtu_on_req = 5'h00;
    logic [4:0] rtu_off_req = 5'h00, name_idx = 5'h00, name_rd_idx = 5'h00, switch_out;
    logic [2:0] name_sw = 3'h0, name_rd_sw = 3'h0, event_switch;
    logic [1:0] mimic_level = 2'h0, access_level_cfg = 2'h2, event_sel_cfg = CSUB_EVSEL_BOTH;
    logic [7:0] name_char = 8'h00, name_rd_char;
    logic [11:0] button_raw, button_mode_cfg = 12'h002, led_red_src = 12'h000;
    logic [11:0] led_orange_src = 12'h000, led_green_src = 12'h000, button_on, button_off;
    logic [11:0] led_red, led_orange, led_green;
    int errors = 0, comparisons = 0;
    csub_top u_dut (.core_clk, .rst_b, .time_now, .mimic_on_req, .mimic_off_req, .mimic_level,
        .access_level_cfg, .rtu_on_req, .rtu_off_req, .event_sel_cfg, .name_wr, .name_sw,
        .name_idx, .name_char, .name_rd_sw, .name_rd_idx, .name_rd_char, .switch_out,
        .event_valid, .event_switch, .event_is_on, .event_time, .button_raw,
        .button_mode_cfg, .led_red_src, .led_orange_src, .led_green_src, .button_on,
        .button_off, .led_red, .led_orange, .led_green);
    csub_panel u_panel (.core_clk, .button_raw);
    // 50 MHz clock
    always #10 core_clk = ~core_clk;
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // one-cycle command; slice 3 mimic on, 2 mimic off, 1 remote on, 0 remote off
    task automatic cmd(input logic m, input int s, input logic on, input logic [31:0] ts);
        @(posedge core_clk);
        time_now <= ts;
        {mimic_on_req, mimic_off_req, rtu_on_req, rtu_off_req} <= 20'h0_0001 << (s + 5 * {m, on});
        @(posedge core_clk);
        {mimic_on_req, mimic_off_req, rtu_on_req, rtu_off_req} <= 20'h0_0000;
        #1;
    endtask
    // event follows the switch edge by one cycle
    task automatic ev(input logic v, input int s, input logic on, input logic [31:0] ts);
        cyc(1);
        chk(event_valid, v);
        if (v) begin
            chk(event_switch, s);
            chk(event_is_on, on);
            chk(event_time, ts);
        end
    endtask
    task automatic t_reset;
        chk(switch_out, 5'h00);
        chk({button_on, button_off}, 24'h000_fff);
        chk(event_valid, 1'b0);
    endtask
    task automatic t_switch;
        cmd(0, 0, 1, 32'h0000_0011);
        chk(switch_out, 5'h01);
        ev(1, 0, 1, 32'h0000_0011);
        cmd(0, 0, 1, 32'h0000_0012);
        ev(0, 0, 1, 0);
        cmd(0, 4, 1, 32'h0000_0013);
        chk(switch_out, 5'h11);
        ev(1, 4, 1, 32'h0000_0013);
        cmd(0, 0, 0, 32'h0000_0014);
        chk(switch_out, 5'h10);
        ev(1, 0, 0, 32'h0000_0014);
        // on then off on consecutive edges: both events must survive
        @(posedge core_clk);
        {time_now, rtu_on_req} <= {32'h0000_0015, 5'h08};
        @(posedge core_clk);
        {rtu_on_req, rtu_off_req} <= {5'h00, 5'h08};
        @(posedge core_clk);
        rtu_off_req <= 5'h00;
        #1;
        chk(switch_out, 5'h10);
        chk(event_valid, 1'b1);
        chk(event_switch, 3'h3);
        chk(event_is_on, 1'b1);
        ev(1, 3, 0, 32'h0000_0015);
    endtask
    // mimic below the required level is refused, at or above accepted
    task automatic t_level;
        mimic_level <= 2'h1;
        cmd(1, 2, 1, 32'h0000_0021);
        ev(0, 2, 1, 0);
        mimic_level <= 2'h2;
        cmd(1, 2, 1, 32'h0000_0022);
        chk(switch_out, 5'h14);
        ev(1, 2, 1, 32'h0000_0022);
        mimic_level <= 2'h3;
        cmd(1, 2, 0, 32'h0000_0023);
        ev(1, 2, 0, 32'h0000_0023);
    endtask
    task automatic t_select;
        event_sel_cfg <= CSUB_EVSEL_ON;
        cmd(0, 1, 1, 32'h0000_0031);
        ev(1, 1, 1, 32'h0000_0031);
        cmd(0, 1, 0, 32'h0000_0032);
        chk(switch_out, 5'h10);
        ev(0, 1, 0, 0);
        event_sel_cfg <= CSUB_EVSEL_OFF;
        cmd(0, 1, 1, 32'h0000_0033);
        ev(0, 1, 1, 0);
    endtask
    // back-to-back character writes, then read both back
    task automatic t_name;
        {name_wr, name_sw, name_idx, name_char} <= {1'b1, 3'h4, 5'h1f, 8'h5a};
        cyc(1);
        {name_sw, name_idx, name_char} <= {3'h0, 5'h00, 8'ha5};
        cyc(1);
        {name_wr, name_rd_sw, name_rd_idx} <= {1'b0, 3'h4, 5'h1f};
        cyc(1);
        chk(name_rd_char, 8'h5a);
        {name_rd_sw, name_rd_idx} <= 8'h00;
        cyc(1);
        chk(name_rd_char, 8'ha5);
        {led_red_src, led_orange_src, led_green_src} <= 36'h0a5_5a0_f0f;
        #1;
        chk({led_red, led_orange, led_green}, 36'h0a5_5a0_f0f);
    endtask
    // button 0 momentary, button 1 toggle; chatter must not count as presses
    task automatic t_button;
        u_panel.bounce(0, 1'b1);
        cyc(100);
        chk(button_on, 12'h000);
        cyc(450);
        chk({button_on, button_off}, 24'h001_ffe);
        u_panel.bounce(0, 1'b0);
        u_panel.bounce(1, 1'b1);
        cyc(550);
        chk({button_on, button_off}, 24'h002_ffd);
        u_panel.bounce(1, 1'b0);
        cyc(550);
        chk(button_on, 12'h002);
        u_panel.bounce(1, 1'b1);
        cyc(550);
        chk({button_on, button_off}, 24'h000_fff);
    endtask
    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        cyc(1);
        t_reset;
        t_switch;
        t_level;
        t_select;
        t_name;
        t_button;
        summarize;
    end
    // watchdog, several times the expected run
    initial begin
        #400_000;
        errors++;
        summarize;
    end
endmodule // control_switch_and_user_buttons_bench
`default_nettype wire
